// File: lintc_pkg.sv
// Package of constants and mode encoding for the LIN transceiver control
// What this block does
// - Wake input falling edge moves power-down to ready mode.
// - Transmitter disabled whenever fault/enable pin is low.
// - Bus pull-up disconnected while the transmitter is disabled.
// - Pull fault pin low when transmit low but bus reads high.
// - Pull fault pin low during thermal shutdown.
// - Fault pin stays high when bus matches data or others send.
// - Short fault only valid 25 us after transmit data falls.
// - Bus driven dominant while transmit data low, released when high.
// - Internal transmit data forced to one while transmitter disabled.
// - Transmit data low over 10 ms forces recessive and transmitter-off.
// - After transmit timeout, re-enable on transmit data rising edge.
// - Receive output mirrors the bus pin level.
// - Bus dominant for 25 ms deactivates the transmitter.
// - Bus-dominant timer clears on any recessive bus level.
// - After bus timeout, re-enable on recessive bus with select high.
// - Fault pin driven low to show transmitter-off after bus timeout.
// - Regulator enable high in every mode except power-down.
// - Select fall in operation or transmitter-off enters power-down.
// - Select rise in ready: operation, or transmitter-off if data low.
// - In power-down, bus activity, select high or wake fall go to ready.
// - Transmitter-off returns to operation when faults clear and pin and transmit data are high.
package lintc_pkg;
    localparam int CLK_HZ = 20_000_000;
    localparam int FAULT_VALID_US = 25;
    localparam int TXD_TIMEOUT_MS = 10;
    localparam int BUS_TIMEOUT_MS = 25;
    localparam int BUS_DEBOUNCE_US = 30;
    // Least times round up, longest round down; all stay at least one cycle
    localparam int FAULT_VALID_CYC = (FAULT_VALID_US * (CLK_HZ / 1000) + 999)
        / 1000;
    localparam int TXD_TIMEOUT_CYC = TXD_TIMEOUT_MS * (CLK_HZ / 1000);
    localparam int BUS_TIMEOUT_CYC = BUS_TIMEOUT_MS * (CLK_HZ / 1000);
    localparam int BUS_DEBOUNCE_CYC = (BUS_DEBOUNCE_US * (CLK_HZ / 1000)
        + 999) / 1000;
    localparam int CNT_W = 20;

    typedef enum logic [2:0] {
        LINTC_READY,
        LINTC_OPERATION,
        LINTC_TRANSMITTER_OFF_MODE,
        LINTC_POWER_DOWN
    } lintc_mode_t;
endpackage

// File: lintc_timer.sv
// Saturating duration counter that flags when a level has lasted long enough
module lintc_timer #(
    parameter int LIMIT = 1
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic run_i,
    output logic expired_o
);
    import lintc_pkg::*;
    localparam logic [CNT_W-1:0] LIMIT_C = CNT_W'(LIMIT);
    logic [CNT_W-1:0] count;
    wire at_limit = (count >= LIMIT_C);

    // Counter clears whenever the watched level drops
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            count <= '0;
        end else if (!run_i) begin
            count <= '0;
        end else if (!at_limit) begin
            count <= count + CNT_W'(1);
        end
    end

    assign expired_o = at_limit;
endmodule

// File: lintc_core.sv
// LIN transceiver mode, fault and timeout control
module lintc_core #(
    parameter int TXD_TIMEOUT = lintc_pkg::TXD_TIMEOUT_CYC,
    parameter int BUS_TIMEOUT = lintc_pkg::BUS_TIMEOUT_CYC
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic txd_i,
    input wire logic select_i,
    input wire logic wake_i,
    input wire logic thermal_shutdown_i,
    input wire logic bus_line_i,
    output logic bus_line_o,
    output logic bus_line_oe_n_o,
    output logic bus_pullup_en_o,
    input wire logic fault_or_tx_enable_i,
    output logic fault_or_tx_enable_o,
    output logic fault_or_tx_enable_oe_n_o,
    output logic rxd_o,
    output logic rxd_oe_n_o,
    output logic regulator_en_o,
    output lintc_pkg::lintc_mode_t mode_o
);
    import lintc_pkg::*;

    // Two-stage synchronisers; first stage read only by second
    logic [5:0] sync_a;
    logic [5:0] sync_b;
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            // Idle pin levels: a high select here would skip ready mode
            sync_a <= 6'h2e;
            sync_b <= 6'h2e;
        end else begin
            sync_a <= {txd_i, select_i, wake_i, bus_line_i,
                fault_or_tx_enable_i, thermal_shutdown_i};
            sync_b <= sync_a;
        end
    end
    wire txd_s = sync_b[5];
    wire sel_s = sync_b[4];
    wire wake_s = sync_b[3];
    wire bus_s = sync_b[2];
    wire fte_s = sync_b[1];
    wire therm_s = sync_b[0];

    // Previous values for edge detection
    logic txd_d;
    logic sel_d;
    logic wake_d;
    logic sel_seen;
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            txd_d <= 1'b1;
            sel_d <= 1'b0;
            wake_d <= 1'b1;
            sel_seen <= 1'b0;
        end else begin
            txd_d <= txd_s;
            sel_d <= sel_s;
            wake_d <= wake_s;
            sel_seen <= 1'b1;
        end
    end
    wire txd_fall = txd_d & ~txd_s;
    wire txd_rise = ~txd_d & txd_s;
    // Select high already at power-up counts as a rising edge
    wire sel_rise = sel_s & (~sel_d | ~sel_seen);
    wire sel_fall = sel_d & ~sel_s;
    wire wake_fall = wake_d & ~wake_s;

    lintc_mode_t mode;
    logic txd_to_latched;
    logic bus_to_latched;
    logic short_fault;
    logic own_fault_drive;

    // Timers: transmit dominant, bus dominant, bus activity, fault validity
    logic txd_expired;
    logic bus_expired;
    logic activity;
    logic fault_window_ok;
    lintc_timer #(.LIMIT(TXD_TIMEOUT)) u_txd_timer (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .run_i(~txd_s),
        .expired_o(txd_expired)
    );
    lintc_timer #(.LIMIT(BUS_TIMEOUT)) u_bus_timer (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .run_i(~bus_s),
        .expired_o(bus_expired)
    );
    lintc_timer #(.LIMIT(BUS_DEBOUNCE_CYC)) u_activity (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .run_i(~bus_s),
        .expired_o(activity)
    );
    // Window restarts on each transmit fall; propagation masks false shorts
    lintc_timer #(.LIMIT(FAULT_VALID_CYC)) u_fault_window (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .run_i(~txd_s & ~txd_fall),
        .expired_o(fault_window_ok)
    );

    // External low with our own drive off means the host commands disable
    wire ext_disable = ~fte_s & ~own_fault_drive;
    wire tx_allowed = (mode == LINTC_OPERATION) & fte_s;
    // Effective transmit data is forced high whenever disabled
    wire txd_eff = tx_allowed ? txd_s : 1'b1;

    // Short to supply: drive low while bus reads high; valid after window
    wire short_now = tx_allowed & ~txd_s & bus_s & fault_window_ok;
    // Fault reporting: short held until data rises, thermal, bus timeout
    wire next_own_fault = short_fault | short_now | therm_s
        | bus_to_latched;
    wire any_fault = therm_s | txd_to_latched | bus_to_latched | short_fault;

    // Latched fault flags; setting wins over clearing in the same cycle
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            txd_to_latched <= 1'b0;
            bus_to_latched <= 1'b0;
            short_fault <= 1'b0;
        end else begin
            if (txd_expired && mode == LINTC_OPERATION) begin
                txd_to_latched <= 1'b1;
            end else if (txd_rise) begin
                txd_to_latched <= 1'b0;
            end
            if (bus_expired && mode == LINTC_OPERATION) begin
                bus_to_latched <= 1'b1;
            end else if (bus_s && sel_s) begin
                bus_to_latched <= 1'b0;
            end
            if (short_now) begin
                short_fault <= 1'b1;
            end else if (txd_s) begin
                short_fault <= 1'b0;
            end
        end
    end

    // Mode transitions
    lintc_mode_t next_mode;
    always_comb begin
        next_mode = mode;
        unique case (mode)
            LINTC_POWER_DOWN: begin
                if (activity || sel_s || wake_fall) begin
                    next_mode = LINTC_READY;
                end
            end
            LINTC_READY: begin
                if (sel_rise || sel_s) begin
                    next_mode = txd_s ? LINTC_OPERATION
                        : LINTC_TRANSMITTER_OFF_MODE;
                end
            end
            LINTC_OPERATION: begin
                if (sel_fall) begin
                    next_mode = LINTC_POWER_DOWN;
                end else if (any_fault || txd_expired || bus_expired
                    || ext_disable || ~fte_s) begin
                    next_mode = LINTC_TRANSMITTER_OFF_MODE;
                end
            end
            LINTC_TRANSMITTER_OFF_MODE: begin
                if (sel_fall) begin
                    next_mode = LINTC_POWER_DOWN;
                end else if (!any_fault && fte_s && txd_s && sel_s) begin
                    next_mode = LINTC_OPERATION;
                end
            end
        endcase
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            mode <= LINTC_READY;
        end else begin
            mode <= next_mode;
        end
    end

    // Registered pin outputs; open-drain enables are active low
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            own_fault_drive <= 1'b0;
            bus_line_oe_n_o <= 1'b1;
            bus_pullup_en_o <= 1'b0;
            fault_or_tx_enable_oe_n_o <= 1'b1;
            rxd_oe_n_o <= 1'b1;
            regulator_en_o <= 1'b0;
            mode_o <= LINTC_READY;
        end else begin
            own_fault_drive <= next_own_fault;
            fault_or_tx_enable_oe_n_o <= ~next_own_fault;
            bus_line_oe_n_o <= txd_eff;
            bus_pullup_en_o <= (next_mode == LINTC_OPERATION);
            rxd_oe_n_o <= bus_s;
            regulator_en_o <= (next_mode != LINTC_POWER_DOWN);
            mode_o <= next_mode;
        end
    end

    // Open-drain pins only ever pull low
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            bus_line_o <= 1'b0;
            fault_or_tx_enable_o <= 1'b0;
            rxd_o <= 1'b0;
        end else begin
            bus_line_o <= 1'b0;
            fault_or_tx_enable_o <= 1'b0;
            rxd_o <= 1'b0;
        end
    end
endmodule

// File: lintc_props.sv
// Port checker for the LIN transceiver control
module lintc_props
    import lintc_pkg::*;
#(
    parameter int TXD_TIMEOUT = 1,
    parameter int BUS_TIMEOUT = 1
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic txd_i,
    input wire logic select_i,
    input wire logic wake_i,
    input wire logic thermal_shutdown_i,
    input wire logic bus_line_i,
    input wire logic fault_or_tx_enable_i,
    input wire logic bus_line_oe_n_o,
    input wire logic bus_pullup_en_o,
    input wire logic rxd_oe_n_o,
    input wire logic fault_or_tx_enable_oe_n_o,
    input wire logic regulator_en_o,
    input wire lintc_pkg::lintc_mode_t mode_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    int txd_low;
    int bus_low;
    // Lengths of the present low runs of transmit data and of the bus
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            txd_low <= 0;
            bus_low <= 0;
        end else begin
            txd_low <= txd_i ? 0 : txd_low + 1;
            bus_low <= bus_line_i ? 0 : bus_low + 1;
        end
    end
    // Repetitions allow for two sync stages plus the output register
    sequence asleep_woken;
        mode_o == LINTC_POWER_DOWN ##0 $fell(wake_i);
    endsequence
    wake_up_a: assert property (asleep_woken |-> ##[1:6]
        mode_o != LINTC_POWER_DOWN) else $error("wake ignored");
    select_sleep_a: assert property ($fell(select_i) &&
        mode_o == LINTC_OPERATION |-> ##[1:6] mode_o == LINTC_POWER_DOWN)
        else $error("select fall ignored");
    pin_disable_a: assert property ((!fault_or_tx_enable_i)[*5]
        |-> bus_line_oe_n_o) else $error("driver on with pin low");
    pullup_off_a: assert property ((mode_o != LINTC_OPERATION)[*3]
        |-> !bus_pullup_en_o) else $error("pull-up left on");
    thermal_flag_a: assert property ((thermal_shutdown_i && mode_o
        inside {LINTC_OPERATION, LINTC_TRANSMITTER_OFF_MODE})[*5]
        |-> !fault_or_tx_enable_oe_n_o) else $error("thermal not flagged");
    drive_low_a: assert property ((mode_o == LINTC_OPERATION &&
        fault_or_tx_enable_i && !txd_i)[*5] |-> !bus_line_oe_n_o)
        else $error("bus not driven");
    release_high_a: assert property (txd_i[*5] |-> bus_line_oe_n_o)
        else $error("bus not released");
    rxd_mirror_a: assert property (($stable(bus_line_i) &&
        mode_o != LINTC_POWER_DOWN)[*5] |-> rxd_oe_n_o == bus_line_i)
        else $error("receive output wrong");
    txd_limit_a: assert property (txd_low > TXD_TIMEOUT + 4
        |-> bus_line_oe_n_o) else $error("data timeout missed");
    // Margin covers two sync stages plus the mode register
    bus_limit_a: assert property (bus_low > BUS_TIMEOUT + 4
        && select_i |-> mode_o != LINTC_OPERATION)
        else $error("bus timeout missed");
    // Outputs hold reset values for one edge after release
    regulator_mode_a: assert property (!$past(rst_i) |->
        regulator_en_o == (mode_o != LINTC_POWER_DOWN))
        else $error("regulator enable wrong");
endmodule

// File: lintc_far.sv
// Wired pins shared with the host, another node and a stuck bus
module lintc_far (
    input wire logic bus_oe_n_i,
    input wire logic flt_oe_n_i,
    input wire logic host_off_i,
    input wire logic dom_i,
    input wire logic stuck_i,
    output logic bus_o,
    output logic flt_pin_o
);
    // Pulled-up wires read low while any party sinks them; a stuck bus reads high regardless
    assign bus_o = stuck_i | (bus_oe_n_i & !dom_i);
    assign flt_pin_o = flt_oe_n_i & !host_off_i;
endmodule

// File: lintc_core_tb.sv
// Self-checking bench for the LIN transceiver control
module lintc_core_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import lintc_pkg::*;
    localparam int TXD_TIMEOUT = 1000;
    localparam int BUS_TIMEOUT = 1200;
    logic clk_i = 0, rst_i = 1, txd_i = 1, select_i = 0, wake_i = 1;
    logic thermal_shutdown_i = 0, host_off = 0, dom = 0, stuck = 0;
    logic bus_line_i, fault_or_tx_enable_i, bus_line_o, bus_line_oe_n_o;
    logic bus_pullup_en_o, fault_or_tx_enable_o, fault_or_tx_enable_oe_n_o;
    logic rxd_o, rxd_oe_n_o, regulator_en_o;
    lintc_mode_t mode_o;
    int err_count = 0, compares = 0, cyc = 0;
    // Free-running 20 MHz clock
    always #25 clk_i = ~clk_i;
    lintc_core #(.TXD_TIMEOUT(TXD_TIMEOUT), .BUS_TIMEOUT(BUS_TIMEOUT))
        lintc_core_inst (.*);
    lintc_far lintc_far_inst (.bus_oe_n_i(bus_line_oe_n_o),
        .flt_oe_n_i(fault_or_tx_enable_oe_n_o), .host_off_i(host_off),
        .dom_i(dom), .stuck_i(stuck), .bus_o(bus_line_i),
        .flt_pin_o(fault_or_tx_enable_i));
    // Inputs always move 5 ns after the rising edge
    task automatic step(input int n);
        repeat (n) @(posedge clk_i);
        #5;
    endtask
    task automatic chk(input logic got, input logic exp);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t ns on an output", $time);
        end
    endtask
    task automatic md(input lintc_mode_t m);
        chk(mode_o === m, 1'b1);
    endtask
    // Expected fault pin drive: high means nothing is wrong
    function automatic logic flt_exp(input logic txd, bus, hot);
        return !(hot || (!txd && bus));
    endfunction
    task automatic print_verdict();
        if (err_count == 0 && compares > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // Planned run is about 4400 cycles
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 9000) begin
            err_count++;
            print_verdict();
        end
    end
    initial begin
        void'($urandom(32'h3c56b40e));
        step(5);
        rst_i = 0;
        select_i = 1;
        step(6);
        md(LINTC_OPERATION);
        chk(regulator_en_o, 1'b1);
        chk(bus_pullup_en_o, 1'b1);
        // Short random bursts stay far below both timeouts
        for (int i = 0; i < 30; i++) begin
            txd_i = 1'($urandom);
            dom = 1'($urandom);
            // Bus read-back takes three more edges to reach the receive pin
            step(7);
            chk(bus_line_oe_n_o, txd_i);
            chk(rxd_oe_n_o, bus_line_i);
            chk(fault_or_tx_enable_oe_n_o,
                flt_exp(txd_i, bus_line_i, 0));
        end
        chk(bus_line_o | fault_or_tx_enable_o | rxd_o, 1'b0);
        // A fresh falling edge restarts the fault validity window
        txd_i = 1;
        dom = 0;
        step(4);
        txd_i = 0;
        stuck = 1;
        step(FAULT_VALID_CYC - 20);
        chk(fault_or_tx_enable_oe_n_o, 1'b1);
        step(30);
        chk(fault_or_tx_enable_oe_n_o, flt_exp(0, 1, 0));
        chk(bus_line_oe_n_o, 1'b1);
        txd_i = 1;
        stuck = 0;
        step(8);
        md(LINTC_OPERATION);
        thermal_shutdown_i = 1;
        step(6);
        chk(fault_or_tx_enable_oe_n_o, flt_exp(1, 1, 1));
        thermal_shutdown_i = 0;
        host_off = 1;
        txd_i = 0;
        step(6);
        chk(bus_line_oe_n_o, 1'b1);
        chk(bus_pullup_en_o, 1'b0);
        chk(fault_or_tx_enable_oe_n_o, 1'b1);
        host_off = 0;
        txd_i = 1;
        step(8);
        txd_i = 0;
        step(TXD_TIMEOUT + 10);
        md(LINTC_TRANSMITTER_OFF_MODE);
        txd_i = 1;
        step(8);
        md(LINTC_OPERATION);
        // Two dominant runs split by a recessive gap; the first stays under the limit, the second runs past it
        dom = 1;
        step(BUS_TIMEOUT - 500);
        dom = 0;
        step(4);
        dom = 1;
        step(BUS_TIMEOUT - 500);
        md(LINTC_OPERATION);
        step(510);
        chk(fault_or_tx_enable_oe_n_o, 1'b0);
        md(LINTC_TRANSMITTER_OFF_MODE);
        dom = 0;
        step(8);
        md(LINTC_OPERATION);
        select_i = 0;
        step(6);
        chk(regulator_en_o, 1'b0);
        wake_i = 0;
        step(6);
        md(LINTC_READY);
        // Select rising while transmit data is held low
        wake_i = 1;
        txd_i = 0;
        select_i = 1;
        step(6);
        md(LINTC_TRANSMITTER_OFF_MODE);
        select_i = 0;
        step(6);
        md(LINTC_POWER_DOWN);
        // Debounced bus activity wakes the block from power-down
        dom = 1;
        step(BUS_DEBOUNCE_CYC + 10);
        md(LINTC_READY);
        chk(regulator_en_o, 1'b1);
        dom = 0;
        txd_i = 1;
        select_i = 1;
        step(6);
        md(LINTC_OPERATION);
        // Reset in mid-run with select low must stay in ready afterwards
        rst_i = 1;
        select_i = 0;
        step(2);
        md(LINTC_READY);
        chk(bus_pullup_en_o, 1'b0);
        rst_i = 0;
        step(3);
        md(LINTC_READY);
        print_verdict();
    end
endmodule
bind lintc_core lintc_props #(.TXD_TIMEOUT(TXD_TIMEOUT),
    .BUS_TIMEOUT(BUS_TIMEOUT)) lintc_props_inst (.*);
